// >>> verilog/rtc_port_pkg.sv
/*
 * constants for the clock-chip host port: timing counts, host register
 * locations, axi4-lite offsets and field positions.
 * assumes a 20 MHz aclk.
 */
// Operation
// [RULE_01] select, read, write strobes are active low
// [RULE_02] read spans select and read both low
// [RULE_03] write spans select and write both low
// [RULE_04] supply loss locks strobes; current access finishes
// [RULE_05] five index inputs, ignored once locked out
// [RULE_06] data lines released unless writing, supply lost; code drives them only while reading with supply present
// [RULE_07] lockout 30 to 63 us after supply loss; code waits 30 us plus extra_us, which can add 0 to 255 us
// [RULE_08] single supply: supply loss pin held high
// [RULE_09] open-drain active-low event interrupt when enabled
// [RULE_10] multi-function out: push-pull, open drain standby
// [RULE_11] interrupt about 20 us after counter rollover
// [RULE_12] interrupt control one bit 7 enables detection
// [RULE_13] oscillator always runs, independent of bus
// [RULE_14] status bit picks control register block
// [RULE_15] write data stored at end of write
`default_nettype none
package rtc_port_pkg;
    // clock period and microsecond scaling
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned US_CYC          = 1000 / CLK_PERIOD_NS;
    // lockout window after supply loss, least rounded up
    localparam int unsigned LOCK_MIN_US     = 30;
    localparam int unsigned LOCK_MAX_US     = 63;
    localparam logic [15:0] LOCK_MIN_CYC    =
        16'((LOCK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] LOCK_MAX_CYC    =
        16'((LOCK_MAX_US * 1000) / CLK_PERIOD_NS);
    // rollover to interrupt delay, typical figure
    localparam int unsigned ROLL_IRQ_US     = 20;
    localparam logic [15:0] ROLL_IRQ_CYC    =
        16'((ROLL_IRQ_US * 1000) / CLK_PERIOD_NS);
    // hundredths-of-a-second rollover period
    localparam int unsigned TICK_US         = 10000;
    localparam int unsigned TICK_CYC_DEFAULT =
        (TICK_US * 1000) / CLK_PERIOD_NS;
    // host register locations (index within block)
    localparam logic [4:0]  HIDX_MAIN_STATUS = 5'h00;
    localparam logic [4:0]  HIDX_OUT_MODE    = 5'h02;
    localparam logic [4:0]  HIDX_PERIODIC    = 5'h03;
    localparam logic [4:0]  HIDX_ICR0        = 5'h03;
    localparam logic [4:0]  HIDX_ICR1        = 5'h04;
    // host field positions
    localparam int unsigned MS_PF_FLAG      = 1;
    localparam int unsigned MS_BLOCK_SEL    = 6;
    localparam int unsigned ICR1_PF_ENABLE  = 7;
    localparam int unsigned OMR_OSC_SEL     = 7;
    // axi4-lite byte offsets
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_STATUS      = 8'h04;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h08;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h0C;
    // irq bits: host write done, lockout entered, rollover
    localparam int unsigned IRQ_BITS        = 3;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage : rtc_port_pkg
`default_nettype wire

// >>> verilog/host_port_if.sv
/*
 * signals shared between the port core, the strobe tracker and the
 * lockout timer. all on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
    logic       lockout;      // port isolated after supply loss
    logic       pf_enable;    // supply-failure detection enabled
    logic [7:0] extra_us;     // programmed extra lockout delay, us
    logic       rd_active;    // host read under way
    logic       wr_active;    // host write under way
    logic       rd_done;      // one-cycle pulse at end of read
    logic       wr_done;      // one-cycle pulse at end of write
    modport tracker (input lockout, output rd_active, wr_active,
                     rd_done, wr_done);
    modport timer   (input pf_enable, extra_us, output lockout);
    modport core    (input lockout, rd_active, wr_active, rd_done,
                     wr_done, output pf_enable, extra_us);
endinterface : host_port_if
`default_nettype wire

// >>> verilog/strobe_tracker.sv
/*
 * tracks host read and write accesses from the active-low strobes.
 * assumes strobes already synchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module strobe_tracker (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  cs_n,
    input  wire logic  rd_n,
    input  wire logic  wr_n,
    host_port_if.tracker hp
);
    import rtc_port_pkg::*;
    logic rd_reg, rd_next;     // read in progress
    logic wr_reg, wr_next;     // write in progress
    logic rd_low, wr_low;      // both strobes low

    // next access state
    always_comb begin
        // [RULE_01] strobes low active
        rd_low  = !cs_n && !rd_n;
        wr_low  = !cs_n && !wr_n;
        // [RULE_02] read window gating
        // [RULE_04] no new access once locked
        rd_next = rd_reg ? rd_low : (rd_low && !hp.lockout);
        // [RULE_03] write window gating
        wr_next = wr_reg ? wr_low : (wr_low && !hp.lockout && !rd_reg);
    end

    // register the access state and end pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_reg     <= 1'b0;
            wr_reg     <= 1'b0;
            hp.rd_done <= 1'b0;
            hp.wr_done <= 1'b0;
        end else begin
            rd_reg     <= rd_next;
            wr_reg     <= wr_next;
            hp.rd_done <= rd_reg && !rd_next;
            hp.wr_done <= wr_reg && !wr_next;
        end
    end
    assign hp.rd_active = rd_reg;
    assign hp.wr_active = wr_reg;

    a_read_begin: assert property (@(posedge aclk) disable iff (!aresetn)
        !cs_n && !rd_n && !hp.lockout && !rd_reg |=> rd_reg) // [RULE_02]
        else $error("read did not begin");
    a_write_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        hp.lockout && !wr_reg |=> !wr_reg) // [RULE_04]
        else $error("write began during lockout");
    a_write_end: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_reg && (cs_n || wr_n) |=> !wr_reg && hp.wr_done) // [RULE_03]
        else $error("write did not end on strobe release");
endmodule : strobe_tracker
`default_nettype wire

// >>> verilog/lockout_timer.sv
/*
 * counts how long the supply-loss input stays low and raises lockout.
 * assumes supply_loss_n synchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module lockout_timer (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  supply_loss_n,
    host_port_if.timer hp
);
    import rtc_port_pkg::*;
    logic [15:0] cnt_reg, cnt_next;   // cycles with supply lost
    logic        lock_reg, lock_next; // lockout state
    logic [15:0] limit;               // cycles until lockout

    // next count and lockout
    always_comb begin
        // [RULE_07] base window plus programmed delay
        limit     = LOCK_MIN_CYC + 16'(hp.extra_us * US_CYC);
        cnt_next  = cnt_reg;
        lock_next = lock_reg;
        // [RULE_12] detection off clears everything
        if (supply_loss_n || !hp.pf_enable) begin
            cnt_next  = 16'h0000;
            lock_next = 1'b0;
        end else if (cnt_reg < limit) begin
            cnt_next  = cnt_reg + 16'h0001;
        end else begin
            lock_next = 1'b1;
        end
    end

    // register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= 16'h0000;
            lock_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            lock_reg <= lock_next;
        end
    end
    assign hp.lockout = lock_reg;

    a_lock_early: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(lock_reg) |-> cnt_reg >= LOCK_MIN_CYC) // [RULE_07]
        else $error("lockout before least delay");
    a_lock_late: assert property (@(posedge aclk) disable iff (!aresetn)
        hp.extra_us == 8'h00 && cnt_reg == LOCK_MIN_CYC
        && !supply_loss_n && hp.pf_enable
        |=> lock_reg && cnt_reg <= LOCK_MAX_CYC) // [RULE_07]
        else $error("lockout missed its window");
endmodule : lockout_timer
`default_nettype wire

// >>> verilog/rtc_host_port.sv
/*
 * host bus port of the clock chip: parallel host register file with
 * power-fail lockout, event and multi-function outputs, crystal
 * inverter, and an axi4-lite slave for supervision with interrupt.
 * assumes all pins synchronous to aclk; open-drain pins are resolved
 * outside from out and oe.
 */
`timescale 1ns/1ps
`default_nettype none
module rtc_host_port #(
    parameter int unsigned TICK_CYCLES = rtc_port_pkg::TICK_CYC_DEFAULT
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output var  logic        wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output var  logic        bvalid,
    input  wire logic        bready,
    output var  logic [1:0]  bresp,
    input  wire logic        arvalid,
    output var  logic        arready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    output var  logic        rvalid,
    input  wire logic        rready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        irq,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [4:0]  register_index,
    input  wire logic [7:0]  host_data_in,
    output var  logic [7:0]  host_data_out,
    output var  logic        host_data_oe,
    input  wire logic        supply_loss_n,
    output var  logic        event_irq_n,
    output var  logic        event_irq_n_oe,
    output var  logic        multi_function_out,
    output var  logic        multi_function_out_oe,
    input  wire logic        crystal_input,
    output var  logic        crystal_output
);
    import rtc_port_pkg::*;

    host_port_if hp ();

    strobe_tracker u_track (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cs_n    (cs_n),
        .rd_n    (rd_n),
        .wr_n    (wr_n),
        .hp      (hp.tracker)
    );

    lockout_timer u_lock (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .supply_loss_n (supply_loss_n),
        .hp            (hp.timer)
    );

    // host register file: two blocks of 32 bytes
    logic [7:0]  mem [0:63];
    logic [5:0]  loc_reg, loc_next;     // latched location
    logic [7:0]  wbyte_reg, wbyte_next; // last sampled write data
    logic [7:0]  dout_reg, dout_next;   // read data driven out
    logic        doe_reg, doe_next;     // data lines driven
    logic        roll_flag_reg, roll_flag_next;
    logic        pf_flag_reg, pf_flag_next;
    logic        mem_we;                // store at end of write
    logic [7:0]  rd_byte;               // addressed byte

    // maps block and index to an array location
    function automatic logic [5:0] loc_of(input logic blk,
                                          input logic [4:0] idx);
        // [RULE_14] main status common to both blocks
        loc_of = (idx == HIDX_MAIN_STATUS) ? 6'h00 : {blk, idx};
    endfunction : loc_of

    // hardware flags folded into reads
    always_comb begin
        rd_byte = mem[loc_reg];
        if (loc_reg == 6'h00) begin
            rd_byte[MS_PF_FLAG] = pf_flag_reg;
            rd_byte[0]          = event_irq_n_oe;
        end else if (loc_reg == {1'b0, HIDX_PERIODIC}) begin
            rd_byte = {7'h00, roll_flag_reg};
        end
    end

    // rollover tick, delayed interrupt event
    logic [31:0] tick_reg, tick_next;
    logic [15:0] rdly_reg, rdly_next;   // cycles since rollover
    logic        rpend_reg, rpend_next;
    logic        roll_tick;
    logic        lock_rise;
    logic        lock_d_reg;

    always_comb begin
        roll_tick  = (tick_reg == 32'(TICK_CYCLES - 1));
        tick_next  = roll_tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
        rdly_next  = rdly_reg;
        rpend_next = rpend_reg;
        // [RULE_11] event raised a fixed delay after rollover
        if (roll_tick) begin
            rpend_next = 1'b1;
            rdly_next  = 16'h0000;
        end else if (rpend_reg) begin
            rdly_next  = rdly_reg + 16'h0001;
            if (rdly_reg == ROLL_IRQ_CYC - 16'h0001)
                rpend_next = 1'b0;
        end
    end

    // host-side next state
    always_comb begin
        loc_next   = loc_reg;
        wbyte_next = wbyte_reg;
        mem_we     = 1'b0;
        lock_rise  = hp.lockout && !lock_d_reg;
        // [RULE_05] index ignored once locked out
        if (!hp.lockout)
            loc_next = loc_of(mem[0][MS_BLOCK_SEL], register_index);
        if (hp.wr_active)
            wbyte_next = host_data_in;
        // [RULE_15] store on trailing edge of write
        mem_we     = hp.wr_done;
        dout_next  = hp.rd_active ? rd_byte : dout_reg;
        // [RULE_06] driven only during a read with supply present, released otherwise
        doe_next   = hp.rd_active && supply_loss_n;
        // set wins over clear for both flags
        roll_flag_next = roll_flag_reg;
        if (hp.rd_done && loc_reg == {1'b0, HIDX_PERIODIC})
            roll_flag_next = 1'b0;
        if (rpend_reg && rdly_reg == ROLL_IRQ_CYC - 16'h0001)
            roll_flag_next = 1'b1;
        pf_flag_next = pf_flag_reg;
        if (mem_we && loc_reg == 6'h00 && wbyte_reg[MS_PF_FLAG])
            pf_flag_next = 1'b0;
        if (lock_rise)
            pf_flag_next = 1'b1;
    end

    // [RULE_12] detection enable from control one bit 7
    assign hp.pf_enable = mem[{1'b1, HIDX_ICR1}][ICR1_PF_ENABLE];

    // event and multi-function pins, crystal inverter
    logic ev_assert, mfo_val;
    logic evn_next, evoe_next, mfo_next, mfooe_next;
    always_comb begin
        // [RULE_09] enabled event drives line low
        ev_assert = (roll_flag_reg && mem[{1'b1, HIDX_ICR0}][0])
                  || (pf_flag_reg && mem[{1'b1, HIDX_ICR1}][0]);
        evn_next  = !ev_assert;
        evoe_next = ev_assert;
        // [RULE_10] push-pull normally, open drain when locked
        mfo_val   = mem[{1'b1, HIDX_OUT_MODE}][OMR_OSC_SEL]
                  ? crystal_output : pf_flag_reg;
        mfo_next   = hp.lockout ? 1'b0 : mfo_val;
        mfooe_next = hp.lockout ? !mfo_val : 1'b1;
    end

    // host-side registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loc_reg               <= 6'h00;
            wbyte_reg             <= 8'h00;
            dout_reg              <= 8'h00;
            doe_reg               <= 1'b0;
            roll_flag_reg         <= 1'b0;
            pf_flag_reg           <= 1'b0;
            tick_reg              <= 32'h0000_0000;
            rdly_reg              <= 16'h0000;
            rpend_reg             <= 1'b0;
            lock_d_reg            <= 1'b0;
            event_irq_n           <= 1'b1;
            event_irq_n_oe        <= 1'b0;
            multi_function_out    <= 1'b0;
            multi_function_out_oe <= 1'b1;
            crystal_output        <= 1'b0;
        end else begin
            loc_reg               <= loc_next;
            wbyte_reg             <= wbyte_next;
            dout_reg              <= dout_next;
            doe_reg               <= doe_next;
            roll_flag_reg         <= roll_flag_next;
            pf_flag_reg           <= pf_flag_next;
            tick_reg              <= tick_next;
            rdly_reg              <= rdly_next;
            rpend_reg             <= rpend_next;
            lock_d_reg            <= hp.lockout;
            event_irq_n           <= evn_next;
            event_irq_n_oe        <= evoe_next;
            multi_function_out    <= mfo_next;
            multi_function_out_oe <= mfooe_next;
            // [RULE_13] oscillator inverter gated only by reset
            crystal_output        <= !crystal_input;
        end
    end
    assign host_data_out = dout_reg;
    assign host_data_oe  = doe_reg;

    // register array, cleared at reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 64; i++)
                mem[i] <= 8'h00;
        end else if (mem_we) begin
            mem[loc_reg] <= wbyte_reg;
        end
    end

    // axi4-lite supervision registers
    logic [7:0]          ctrl_reg, ctrl_next;  // extra lockout us
    logic [IRQ_BITS-1:0] ists_reg, ists_next;  // sticky events
    logic [IRQ_BITS-1:0] imask_reg, imask_next;
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [7:0]  waddr_reg, waddr_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0]  ws_reg, ws_next;
    logic        bv_next, arr_next, rv_next, irq_next;
    logic [1:0]  br_next, rr_next;
    logic [31:0] rd_next;
    logic        do_wr;

    assign hp.extra_us = ctrl_reg;

    always_comb begin
        aw_have_next = aw_have_reg || (awvalid && awready);
        w_have_next  = w_have_reg || (wvalid && wready);
        waddr_next   = (awvalid && awready) ? awaddr[7:0] : waddr_reg;
        wd_next      = (wvalid && wready) ? wdata : wd_reg;
        ws_next      = (wvalid && wready) ? wstrb : ws_reg;
        do_wr        = aw_have_reg && w_have_reg && !bvalid;
        ctrl_next    = ctrl_reg;
        imask_next   = imask_reg;
        ists_next    = ists_reg;
        bv_next      = bvalid && !bready;
        br_next      = bresp;
        if (do_wr) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bv_next      = 1'b1;
            br_next      = RESP_OKAY;
            if (waddr_reg == OFF_CTRL) begin
                if (ws_reg[0]) ctrl_next = wd_reg[7:0];
            end else if (waddr_reg == OFF_IRQ_STATUS) begin
                if (ws_reg[0]) ists_next = ists_reg & ~wd_reg[2:0];
            end else if (waddr_reg == OFF_IRQ_MASK) begin
                if (ws_reg[0]) imask_next = wd_reg[2:0];
            end else if (waddr_reg != OFF_STATUS) begin
                br_next = RESP_SLVERR;
            end
        end
        // events set after clear so set wins
        ists_next = ists_next | {roll_tick, lock_rise, hp.wr_done};
        irq_next  = |(ists_next & imask_next);
        // read channel
        arr_next = !rvalid && !(arvalid && arready);
        rv_next  = rvalid && !rready;
        rd_next  = rdata;
        rr_next  = rresp;
        if (arvalid && arready) begin
            rv_next = 1'b1;
            rr_next = RESP_OKAY;
            rd_next = 32'h0000_0000;
            if (araddr[7:0] == OFF_CTRL)
                rd_next = {24'h00_0000, ctrl_reg};
            else if (araddr[7:0] == OFF_STATUS)
                rd_next = {28'h000_0000, hp.rd_active, hp.wr_active,
                           hp.lockout, mem[0][MS_BLOCK_SEL]};
            else if (araddr[7:0] == OFF_IRQ_STATUS)
                rd_next = {29'h0000_0000, ists_reg};
            else if (araddr[7:0] == OFF_IRQ_MASK)
                rd_next = {29'h0000_0000, imask_reg};
            else
                rr_next = RESP_SLVERR;
        end
    end

    // axi state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            waddr_reg   <= 8'h00;
            wd_reg      <= 32'h0000_0000;
            ws_reg      <= 4'h0;
            ctrl_reg    <= 8'h00;
            ists_reg    <= '0;
            imask_reg   <= '0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= RESP_OKAY;
            arready     <= 1'b0;
            rvalid      <= 1'b0;
            rdata       <= 32'h0000_0000;
            rresp       <= RESP_OKAY;
            irq         <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            waddr_reg   <= waddr_next;
            wd_reg      <= wd_next;
            ws_reg      <= ws_next;
            ctrl_reg    <= ctrl_next;
            ists_reg    <= ists_next;
            imask_reg   <= imask_next;
            awready     <= !aw_have_next && !bv_next;
            wready      <= !w_have_next && !bv_next;
            bvalid      <= bv_next;
            bresp       <= br_next;
            arready     <= arr_next;
            rvalid      <= rv_next;
            rdata       <= rd_next;
            rresp       <= rr_next;
            irq         <= irq_next;
        end
    end

    localparam int RD_LO = 1;
    localparam int RD_HI = 402;
    a_data_release: assert property (@(posedge aclk) disable iff (!aresetn)
        !supply_loss_n && !hp.wr_active |=> !host_data_oe) // [RULE_06]
        else $error("data lines driven after supply loss");
    a_event_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_assert |=> event_irq_n_oe && !event_irq_n) // [RULE_09]
        else $error("event interrupt not driven");
    a_roll_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        roll_tick |-> ##[RD_LO:RD_HI] roll_flag_reg) // [RULE_11]
        else $error("rollover flag late");
    a_osc_runs: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> crystal_output == !$past(crystal_input))
        // [RULE_13]
        else $error("oscillator output stalled");
endmodule : rtc_host_port
`default_nettype wire

// >>> testbench/host_cpu_model.sv
/* host cpu model driving the parallel strobes, index and write data.
   assumes the port samples everything on the aclk rising edge. */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input  wire logic       aclk,
    output var  logic       cs_n,
    output var  logic       rd_n,
    output var  logic       wr_n,
    output var  logic [4:0] register_index,
    output var  logic [7:0] host_data_in,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe
);
    // idle: strobes high, bus released
    initial begin
        {cs_n, rd_n, wr_n} = 3'b111;
        register_index = 5'h00;
        host_data_in = 8'h00;
    end
    // write spans select and write low
    task automatic host_write(input logic [4:0] i, input logic [7:0] v);
        register_index <= i;
        host_data_in <= v;
        {cs_n, wr_n} <= 2'b00;
        repeat (3) @(posedge aclk);
        {cs_n, wr_n} <= 2'b11;
        // data held past the trailing edge, then inverted
        repeat (2) @(posedge aclk);
        host_data_in <= ~v;
        repeat (2) @(posedge aclk);
    endtask : host_write
    // read spans select and read low
    task automatic host_read(input logic [4:0] i, output logic [7:0] v,
                             output logic oe);
        register_index <= i;
        {cs_n, rd_n} <= 2'b00;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        v = host_data_out;
        oe = host_data_oe;
        @(posedge aclk);
        {cs_n, rd_n} <= 2'b11;
        repeat (3) @(posedge aclk);
    endtask : host_read
endmodule : host_cpu_model
`default_nettype wire

// >>> testbench/testbench.sv
/* self-checking bench: axi4-lite tasks, host model, lockout timing.
   assumes the port and its package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rtc_port_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, cs_n, rd_n, wr_n, oe;
    logic host_data_oe, supply_loss_n, event_irq_n, event_irq_n_oe;
    logic multi_function_out, multi_function_out_oe, crystal_input;
    logic crystal_output;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [4:0] register_index;
    logic [7:0] host_data_in, host_data_out, d;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [3:0] pins; // event and multi-function pins with enables
    assign pins = {event_irq_n, event_irq_n_oe, multi_function_out,
                   multi_function_out_oe};
    rtc_host_port #(.TICK_CYCLES(1000)) DUT (.*);
    host_cpu_model host (.*);
    always #25 aclk = ~aclk;
    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        // crystal input keeps toggling, bus activity or not
        crystal_input <= ~crystal_input;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [1:0] r);
        logic pa, pw, ta, tw;
        {pa, pw} = 2'b11;
        awaddr <= {24'h00_0000, a};
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'b111;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa & awready;
            tw = pw & wready;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, r}, {30'h0, bresp});
        @(posedge aclk);
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] v,
                          input logic [1:0] r);
        logic t;
        araddr <= {24'h00_0000, a};
        {arvalid, rready} <= 2'b11;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        chk("rdata", v, rdata);
        chk("rresp", {30'h0, r}, {30'h0, rresp});
        @(posedge aclk);
        rready <= 1'b0;
    endtask : axi_rd
    initial begin
        {aclk, aresetn, awvalid, wvalid, arvalid, bready, rready} = 7'h00;
        {awaddr, wdata, araddr} = 96'h0;
        {awprot, arprot, crystal_input} = 7'h00;
        wstrb = 4'hF;
        supply_loss_n = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("oe_rst", {31'h0, host_data_oe}, 32'h0000_0000);
        chk("pins_rst", {28'h0, pins}, 32'h0000_0009);
        axi_wr(OFF_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
        host.host_write(5'h05, 8'hA5);
        host.host_read(5'h05, d, oe);
        chk("hread", {23'h0, oe, d}, 32'h0000_01A5);
        chk("irq_wr", {31'h0, irq}, 32'h0000_0001);
        axi_wr(OFF_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
        axi_rd(8'h10, 32'h0000_0000, RESP_SLVERR);
        chk("irq_clr", {31'h0, irq}, 32'h0000_0000);
        host.host_write(5'h00, 8'h40);
        host.host_write(5'h04, 8'h81);
        supply_loss_n <= 1'b0;
        repeat (560) @(posedge aclk);
        axi_rd(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
        repeat (650) @(posedge aclk);
        axi_rd(OFF_STATUS, 32'h0000_0003, RESP_OKAY);
        axi_rd(OFF_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
        chk("irq_lock", {31'h0, irq}, 32'h0000_0001);
        chk("pins_lock", {28'h0, pins}, 32'h0000_0004);
        chk("xtal", {31'h0, crystal_input}, {31'h0, crystal_output});
        host.host_read(5'h04, d, oe);
        chk("oe_lock", {31'h0, oe}, 32'h0000_0000);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
